// file: shared/wbl_pkg.sv
// Purpose: constants and types shared by the white-balance lookup unit
// Assumes: 8-bit colour channels, one table per channel
// Notes:   page control bit layout lives here and nowhere else
//
// Overview of operation
// [R1] three 256 by 8-bit tables remap channels
// [R2] enabled white balance replaces pixel colours
// [R3] entries writable, readable except during reload
// [R4] host loads tables over serial target port
// [R5] host loads all tables, zeroes unused bits
// [R6] 24-bit source yields 8-bit balanced output
// [R7] 6-bit input needs second dither stage
// [R8] table page blocks main register access
// [R9] write to 0xFF leaves table page
// [R10] host loads red, green, blue in order
// [R11] host loads tables before enabling balance
// [R12] loading locked after init and enable
// [R13] reload option allows seamless live updates
// [R14] reload allows partial updates, no readback
// [R15] page values select red, green, blue
// [R16] page value 0x20 enables white balance
// [R17] second dither stage follows the tables
// [R18] disabled balance passes colours, same latency
package wbl_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] WBL_PAGE_CTRL_OFS = 8'h2A;
  localparam logic [7:0] WBL_PAGE_EXIT_OFS = 8'hFF;
  localparam logic [7:0] WBL_PAGE_RST      = 8'h00;
  localparam logic [7:0] WBL_PAGE_RW_MASK  = 8'hFC;
  localparam int         WBL_SEL_HI        = 7;
  localparam int         WBL_SEL_LO        = 6;
  localparam int         WBL_WB_EN_BIT     = 5;
  localparam int         WBL_PROG_BIT      = 4;
  localparam int         WBL_RELOAD_BIT    = 3;
  localparam int         WBL_DITH_BIT      = 2;
  localparam logic [1:0] WBL_SEL_NONE      = 2'h0;
  localparam logic [1:0] WBL_SEL_RED       = 2'h1;
  localparam logic [1:0] WBL_SEL_GRN       = 2'h2;
  localparam logic [1:0] WBL_SEL_BLU       = 2'h3;
  localparam logic [7:0] WBL_PAGE_RED      = 8'h70;
  localparam logic [7:0] WBL_PAGE_ENABLE   = 8'h20;

  // ************************************************************
  // tables and serial port
  // ************************************************************
  localparam int         WBL_COLOR_W     = 8;
  localparam int         WBL_LUT_ENTRIES = 256;
  localparam int         WBL_NUM_TBL     = 3;
  localparam int         WBL_DITH_DROP   = 2;
  localparam logic [1:0] WBL_LIDX_RED    = 2'h0;
  localparam logic [1:0] WBL_LIDX_GRN    = 2'h1;
  localparam logic [1:0] WBL_LIDX_BLU    = 2'h2;
  localparam logic [3:0] WBL_BYTE_BITS   = 4'h8;
  localparam logic [6:0] WBL_DEV_ADDR_DEF = 7'h2C;
  localparam int         WBL_FIFO_DEPTH  = 16;

  typedef struct packed {
    logic       de;
    logic       hs;
    logic       vs;
    logic [7:0] red;
    logic [7:0] grn;
    logic [7:0] blu;
  } wbl_pix_t;

  localparam int WBL_PIX_W = $bits(wbl_pix_t);

  typedef struct packed {
    logic [1:0] lidx;
    logic [7:0] idx;
    logic [7:0] data;
  } wbl_lutwr_t;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_REG   = 9'h008,
    ST_RGACK = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_RACK  = 9'h100
  } wbl_state_t;

endpackage

// file: src/wbl_fifo.sv
// Purpose: single-clock pixel FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   full and empty come from an extra pointer wrap bit
`timescale 1ns/1ps
module wbl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wrPtr_q;
  logic [AW:0]  rdPtr_q;
  logic         full;
  logic         empty;

  assign full     = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty    = (wrPtr_q == rdPtr_q);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule // wbl_fifo

// file: src/wbl_lut_unit.sv
// Purpose: white-balance tables, serial target port and pixel path
// Assumes: pixel clock runs while tables are written; bytes are far apart
// Notes:   core domain owns registers, pixel domain owns the active tables
`timescale 1ns/1ps
module wbl_lut_unit
  import wbl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = WBL_DEV_ADDR_DEF
) (
  input  wire logic     core_clk,
  input  wire logic     sys_rst,
  input  wire logic     sclIn,
  input  wire logic     sdaIn,
  output logic          sdaOut,
  output logic          sdaOeN,
  input  wire logic     pixClk,
  input  wire logic     pixInValid,
  output logic          pixInReady,
  input  wire wbl_pix_t pixIn,
  output logic          pixOutValid,
  input  wire logic     pixOutReady,
  output wbl_pix_t      pixOut
);

  // ************************************************************
  // serial pin synchronisation and edge detection
  // ************************************************************
  logic [1:0] i2cS;
  logic       sclD_q;
  logic       sdaD_q;
  logic       sclRise;
  logic       sclFall;
  logic       i2cStart;
  logic       i2cStop;

  wbl_sync #(.W(2)) u_i2cSync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   ({sclIn, sdaIn}),
    .q   (i2cS)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclD_q <= 1'b0;
      sdaD_q <= 1'b0;
    end else begin
      sclD_q <= i2cS[1];
      sdaD_q <= i2cS[0];
    end
  end

  assign sclRise  = i2cS[1] && !sclD_q;
  assign sclFall  = !i2cS[1] && sclD_q;
  assign i2cStart = i2cS[1] && sclD_q && sdaD_q && !i2cS[0];
  assign i2cStop  = i2cS[1] && sclD_q && !sdaD_q && i2cS[0];

  // ************************************************************
  // serial target state machine
  // ************************************************************
  wbl_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] offset_q;
  logic       readMode_q;
  logic       sdaLow_q;
  logic       mAck_q;
  logic [7:0] rdByte;
  logic       wrStb;

  // open drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOeN = !sdaLow_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      offset_q   <= 8'h00;
      readMode_q <= 1'b0;
      sdaLow_q   <= 1'b0;
      mAck_q     <= 1'b0;
    end else if (i2cStop) begin
      state_q  <= ST_IDLE;
      sdaLow_q <= 1'b0;
    end else if (i2cStart) begin
      state_q  <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaLow_q <= 1'b0;
    end else if (sclRise) begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_q  <= {shift_q[6:0], i2cS[0]};
          bitCnt_q <= bitCnt_q + 4'h1;
        end
        ST_RDATA: bitCnt_q <= bitCnt_q + 4'h1;
        ST_RACK:  mAck_q <= !i2cS[0];
        default: ;
      endcase
    end else if (sclFall) begin
      case (state_q)
        ST_ADDR: begin
          if (bitCnt_q == WBL_BYTE_BITS) begin
            bitCnt_q <= 4'h0;
            if (shift_q[7:1] == DEV_ADDR) begin // [R4]
              state_q    <= ST_AACK;
              sdaLow_q   <= 1'b1;
              readMode_q <= shift_q[0];
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          bitCnt_q <= 4'h0;
          if (readMode_q) begin
            state_q  <= ST_RDATA;
            shift_q  <= rdByte;
            sdaLow_q <= !rdByte[7];
          end else begin
            state_q  <= ST_REG;
            sdaLow_q <= 1'b0;
          end
        end
        ST_REG: begin
          if (bitCnt_q == WBL_BYTE_BITS) begin
            state_q  <= ST_RGACK;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b1;
            offset_q <= shift_q;
          end
        end
        ST_RGACK: begin
          state_q  <= ST_WDATA;
          sdaLow_q <= 1'b0;
        end
        ST_WDATA: begin
          if (bitCnt_q == WBL_BYTE_BITS) begin
            state_q  <= ST_WACK;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b1;
          end
        end
        ST_WACK: begin
          state_q  <= ST_WDATA;
          sdaLow_q <= 1'b0;
          offset_q <= offset_q + 8'h01;
        end
        ST_RDATA: begin
          if (bitCnt_q == WBL_BYTE_BITS) begin
            state_q  <= ST_RACK;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b0;
            offset_q <= offset_q + 8'h01;
          end else begin
            shift_q  <= {shift_q[6:0], 1'b0};
            sdaLow_q <= !shift_q[6];
          end
        end
        ST_RACK: begin
          if (mAck_q) begin
            state_q  <= ST_RDATA;
            shift_q  <= rdByte;
            sdaLow_q <= !rdByte[7];
          end else begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign wrStb = sclFall && (state_q == ST_WDATA) && (bitCnt_q == WBL_BYTE_BITS);

  // ************************************************************
  // page control register and table access decode
  // ************************************************************
  logic [7:0] pageCtrl_q;
  logic       initDone_q;
  logic       progPage;
  logic [1:0] tblSel;
  logic       tblValid;
  logic [1:0] tblIdx;
  logic       reloadMode;
  logic       lutLocked;
  logic       lutWrGo;

  assign progPage   = pageCtrl_q[WBL_PROG_BIT];
  assign tblSel     = pageCtrl_q[WBL_SEL_HI:WBL_SEL_LO];
  assign tblValid   = (tblSel != WBL_SEL_NONE);
  assign tblIdx     = tblSel - WBL_SEL_RED;
  assign reloadMode = initDone_q && pageCtrl_q[WBL_RELOAD_BIT];
  assign lutLocked  = initDone_q && pageCtrl_q[WBL_WB_EN_BIT] && !pageCtrl_q[WBL_RELOAD_BIT]; // [R12]
  assign lutWrGo    = wrStb && progPage && tblValid && !lutLocked; // [R3] [R13] [R14]

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pageCtrl_q <= WBL_PAGE_RST;
      initDone_q <= 1'b0;
    end else if (wrStb) begin
      if (progPage) begin
        // table page hides the main page; the exit offset is still stored as an entry
        if (offset_q == WBL_PAGE_EXIT_OFS) begin
          pageCtrl_q[WBL_PROG_BIT] <= 1'b0; // [R8] [R9]
        end
      end else if (offset_q == WBL_PAGE_CTRL_OFS) begin
        pageCtrl_q <= shift_q & WBL_PAGE_RW_MASK; // [R15] [R16]
        // table selects carry the enable bit too, so only an enabling write with the table page bit clear ends initial loading
        if (shift_q[WBL_WB_EN_BIT] && !shift_q[WBL_PROG_BIT]) begin
          initDone_q <= 1'b1; // [R12]
        end
      end
    end
  end

  // shadow copy so readback never touches the pixel domain
  logic [7:0] progLut [WBL_NUM_TBL*WBL_LUT_ENTRIES];
  wbl_lutwr_t lutWr_q;
  logic       reqTog_q;
  logic       ackTogS;
  logic       lutBusy;

  always_ff @(posedge core_clk) begin
    if (lutWrGo) begin
      progLut[{tblIdx, offset_q}] <= shift_q; // [R3]
    end
  end

  // hold word stays put until the toggle comes back; bytes are microseconds apart
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lutWr_q  <= '0;
      reqTog_q <= 1'b0;
    end else if (lutWrGo) begin
      lutWr_q  <= '{lidx: tblIdx, idx: offset_q, data: shift_q};
      reqTog_q <= !reqTog_q; // [R13]
    end
  end

  assign lutBusy = (reqTog_q != ackTogS);

  always_comb begin
    rdByte = 8'h00;
    if (progPage) begin
      if (!reloadMode && tblValid) begin
        rdByte = progLut[{tblIdx, offset_q}]; // [R3] [R14]
      end
    end else if (offset_q == WBL_PAGE_CTRL_OFS) begin
      rdByte = pageCtrl_q;
    end
  end

  // ************************************************************
  // pixel domain reset and crossings
  // ************************************************************
  logic       pixRstMeta_q;
  logic       pixRst_q;
  logic [2:0] ctrlS;
  logic       wbEnP;
  logic       dithEnP;
  logic       reqTogS;
  logic       reqTogD_q;
  logic       pixWrGo;

  always_ff @(posedge pixClk or posedge sys_rst) begin
    if (sys_rst) begin
      pixRstMeta_q <= 1'b1;
      pixRst_q     <= 1'b1;
    end else begin
      pixRstMeta_q <= 1'b0;
      pixRst_q     <= pixRstMeta_q;
    end
  end

  wbl_sync #(.W(3)) u_ctrlSync (
    .clk (pixClk),
    .rst (pixRst_q),
    .d   ({pageCtrl_q[WBL_WB_EN_BIT], pageCtrl_q[WBL_DITH_BIT], reqTog_q}),
    .q   (ctrlS)
  );

  assign wbEnP   = ctrlS[2];
  assign dithEnP = ctrlS[1];
  assign reqTogS = ctrlS[0];
  assign pixWrGo = reqTogS ^ reqTogD_q;

  always_ff @(posedge pixClk or posedge pixRst_q) begin
    if (pixRst_q) begin
      reqTogD_q <= 1'b0;
    end else begin
      reqTogD_q <= reqTogS;
    end
  end

  wbl_sync #(.W(1)) u_ackSync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   (reqTogD_q),
    .q   (ackTogS)
  );

  // ************************************************************
  // active tables and pixel pipeline
  // ************************************************************
  logic [7:0] pixLut [WBL_NUM_TBL*WBL_LUT_ENTRIES];
  wbl_pix_t   s1_q;
  wbl_pix_t   s2_q;
  wbl_pix_t   s1_d;
  wbl_pix_t   s2_d;
  logic       s1Valid_q;
  logic       s2Valid_q;
  logic       pipeEn;
  logic       fifoInReady;

  // single-entry writes keep the live picture intact
  always_ff @(posedge pixClk) begin
    if (pixWrGo) begin
      pixLut[{lutWr_q.lidx, lutWr_q.idx}] <= lutWr_q.data; // [R13]
    end
  end

  function automatic logic [7:0] wblDither(input logic [7:0] v);
    logic [6:0] s;
    s = {1'b0, v[WBL_COLOR_W-1:WBL_DITH_DROP]} + {6'h00, v[WBL_DITH_DROP-1]};
    if (s[6]) begin
      s = 7'h3F;
    end
    return {s[5:0], 2'h0};
  endfunction

  always_comb begin
    s1_d = pixIn; // [R18]
    if (wbEnP) begin
      s1_d.red = pixLut[{WBL_LIDX_RED, pixIn.red}]; // [R1] [R2] [R6]
      s1_d.grn = pixLut[{WBL_LIDX_GRN, pixIn.grn}];
      s1_d.blu = pixLut[{WBL_LIDX_BLU, pixIn.blu}];
    end
  end

  always_comb begin
    s2_d = s1_q;
    if (dithEnP) begin
      s2_d.red = wblDither(s1_q.red); // [R7] [R17]
      s2_d.grn = wblDither(s1_q.grn);
      s2_d.blu = wblDither(s1_q.blu);
    end
  end

  assign pipeEn     = fifoInReady || !s2Valid_q;
  assign pixInReady = pipeEn;

  always_ff @(posedge pixClk or posedge pixRst_q) begin
    if (pixRst_q) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s1Valid_q <= 1'b0;
      s2Valid_q <= 1'b0;
    end else if (pipeEn) begin
      s1_q      <= s1_d;
      s2_q      <= s2_d;
      s1Valid_q <= pixInValid;
      s2Valid_q <= s1Valid_q;
    end
  end

  wbl_fifo #(.W(WBL_PIX_W), .DEPTH(WBL_FIFO_DEPTH)) u_fifo (
    .clk      (pixClk),
    .rst      (pixRst_q),
    .inValid  (s2Valid_q),
    .inReady  (fifoInReady),
    .inData   (s2_q),
    .outValid (pixOutValid),
    .outReady (pixOutReady),
    .outData  (pixOut)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  logic [7:0] lookRed;
  assign lookRed = pixLut[{WBL_LIDX_RED, pixIn.red}];

  AST_BYPASS: assert property (@(posedge pixClk) disable iff (pixRst_q) // [R18]
    (pipeEn && !wbEnP) |=> (s1_q.red == $past(pixIn.red)) && (s1_q.blu == $past(pixIn.blu)))
    else $error("bypass changed colour");
  AST_LOOKUP: assert property (@(posedge pixClk) disable iff (pixRst_q) // [R1] [R2]
    (pipeEn && wbEnP) |=> (s1_q.red == $past(lookRed)))
    else $error("red not taken from table");
  AST_DITHER: assert property (@(posedge pixClk) disable iff (pixRst_q) // [R17]
    (pipeEn && dithEnP) |=> (s2_q.red[1:0] == 2'h0) && (s2_q.grn[1:0] == 2'h0))
    else $error("dithered output keeps low bits");
  AST_LUT_WRITE: assert property (@(posedge pixClk) disable iff (pixRst_q) // [R13]
    pixWrGo |=> (pixLut[{$past(lutWr_q.lidx), $past(lutWr_q.idx)}] == $past(lutWr_q.data)))
    else $error("active table not updated");
  AST_EXIT: assert property (@(posedge core_clk) disable iff (sys_rst) // [R9]
    (wrStb && progPage && offset_q == WBL_PAGE_EXIT_OFS) |=> !progPage)
    else $error("table page not left");
  AST_RESTRICT: assert property (@(posedge core_clk) disable iff (sys_rst) // [R8]
    (wrStb && progPage && offset_q == WBL_PAGE_CTRL_OFS) |=> $stable(pageCtrl_q))
    else $error("main register written from table page");
  AST_REJECT: assert property (@(posedge core_clk) disable iff (sys_rst) // [R12]
    (wrStb && lutLocked) |=> $stable(reqTog_q))
    else $error("locked table accepted a write");
  AST_NO_READ: assert property (@(posedge core_clk) disable iff (sys_rst) // [R14]
    (progPage && reloadMode) |-> (rdByte == 8'h00))
    else $error("table readable during reload");
  AST_SEL_RED: assert property (@(posedge core_clk) disable iff (sys_rst) // [R15]
    (wrStb && !progPage && offset_q == WBL_PAGE_CTRL_OFS && shift_q == WBL_PAGE_RED)
    |=> progPage && (tblSel == WBL_SEL_RED))
    else $error("red table not selected");
  AST_ENABLE: assert property (@(posedge core_clk) disable iff (sys_rst) // [R16]
    (wrStb && !progPage && offset_q == WBL_PAGE_CTRL_OFS && shift_q == WBL_PAGE_ENABLE)
    |=> pageCtrl_q[WBL_WB_EN_BIT] && !progPage && initDone_q)
    else $error("white balance not enabled");
  AST_HANDSHAKE: assert property (@(posedge core_clk) disable iff (sys_rst) // [R4]
    $rose(lutBusy) |-> ##[1:12] !lutBusy)
    else $error("table write crossing stuck");

  COV_LUT_WRITE: cover property (@(posedge core_clk) disable iff (sys_rst) lutWrGo);
  COV_RELOAD:    cover property (@(posedge core_clk) disable iff (sys_rst) lutWrGo && reloadMode);
  COV_READ:      cover property (@(posedge core_clk) disable iff (sys_rst) state_q == ST_RDATA);
  COV_STALL:     cover property (@(posedge pixClk) disable iff (pixRst_q) pixInValid && !pixInReady);
endmodule // wbl_lut_unit

// file: src/wbl_sync.sv
// Purpose: two-flop level synchroniser, one lane per bit
// Assumes: each bit is an independent level or toggle
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module wbl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // wbl_sync

// file: tb/wbl_i2c_host.sv
// Purpose: behavioural host controller on the two-wire serial control bus
// Assumes: pull-up on sda, host drives scl high and low, target synchronises both lines
// Notes:   tasks are called by the bench; the host only ever pulls sda low
`timescale 1ns/1ps
module wbl_i2c_host (
  input  wire logic clk,
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  // ****************
  // bit timing
  // ****************
  // each scl level of a data bit lasts six clocks, well above the target's two-flop synchroniser delay
  localparam int HB = 6;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // sda moves two clocks after scl falls so no false start is seen
  task automatic bitIo(input logic b, output logic r);
    sdaLow <= ~b;
    tick(HB - 2);
    scl <= 1'b1;
    tick(HB);
    r = sdaWire;
    scl <= 1'b0;
    tick(2);
  endtask

  // also serves as repeated start
  task automatic start();
    sdaLow <= 1'b0;
    tick(HB);
    scl <= 1'b1;
    tick(HB);
    sdaLow <= 1'b1;
    tick(HB);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic stop();
    sdaLow <= 1'b1;
    tick(HB);
    scl <= 1'b1;
    tick(HB);
    sdaLow <= 1'b0;
    tick(HB);
  endtask

  task automatic putByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], r);
    end
    bitIo(1'b1, r);
    ack = ~r;
  endtask

  // more = 1 acks the byte so the target sends the next one, 0 ends the read
  task automatic getByte(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, v[i]);
    end
    bitIo(~more, r);
  endtask
endmodule // wbl_i2c_host

// file: tb/wbl_lut_unit_tb.sv
// Purpose: self-checking bench for the white-balance lookup unit
// Assumes: host model on the serial pins, bench feeds and drains pixels
// Notes:   three full table loads dominate the run time
`timescale 1ns/1ps
module wbl_lut_unit_tb
  import wbl_pkg::*;
;
  localparam logic [6:0] ADDR = WBL_DEV_ADDR_DEF;
  logic     core_clk;
  logic     sys_rst;
  logic     pixClk;
  logic     pixInValid;
  logic     pixOutReady;
  wbl_pix_t pixIn;
  wbl_pix_t pixOut;
  logic     sclW;
  logic     hostLow;
  logic     sdaOut;
  logic     sdaOeN;
  logic     pixInReady;
  logic     pixOutValid;
  wire      sdaW;
  int       mismatches;
  int       nChecks;

  // pull-up wins unless someone pulls low
  assign sdaW = ~(hostLow | (~sdaOeN & ~sdaOut));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    pixClk = 1'b0;
    #3;
    forever #7.5 pixClk = ~pixClk;
  end

  wbl_lut_unit wbl_lut_unit_inst (.core_clk(core_clk), .sys_rst(sys_rst), .sclIn(sclW), .sdaIn(sdaW),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .pixClk(pixClk), .pixInValid(pixInValid), .pixInReady(pixInReady),
    .pixIn(pixIn), .pixOutValid(pixOutValid), .pixOutReady(pixOutReady), .pixOut(pixOut));
  wbl_i2c_host wbl_i2c_host_inst (.clk(core_clk), .scl(sclW), .sdaLow(hostLow), .sdaWire(sdaW));

  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] lv(input int t, input logic [7:0] i);
    case (t)
      0: lv = ~i;
      1: lv = i ^ 8'h5A;
      default: lv = i + 8'h11;
    endcase
  endfunction

  function automatic logic [7:0] dz(input logic [7:0] v);
    logic [6:0] s;
    s = v[7:2] + v[1];
    dz = (s > 7'h3F) ? 8'hFC : {s[5:0], 2'h0};
  endfunction

  function automatic wbl_pix_t mk(input int i);
    mk = {3'(i), 8'(i), 8'(i * 3), 8'(~i)};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic giveUp(input logic hit);
    if (hit) begin
      mismatches++;
      $display("Error wait expected handshake seen timeout");
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    logic [2:0] a;
    wbl_i2c_host_inst.start();
    wbl_i2c_host_inst.putByte({ADDR, 1'h0}, a[2]);
    wbl_i2c_host_inst.putByte(ofs, a[1]);
    wbl_i2c_host_inst.putByte(val, a[0]);
    wbl_i2c_host_inst.stop();
    check("write acks", a, 3'h7);
  endtask

  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic a;
    wbl_i2c_host_inst.start();
    wbl_i2c_host_inst.putByte({ADDR, 1'h0}, a);
    wbl_i2c_host_inst.putByte(ofs, a);
    wbl_i2c_host_inst.start();
    wbl_i2c_host_inst.putByte({ADDR, 1'h1}, a);
    wbl_i2c_host_inst.getByte(1'h0, v);
    wbl_i2c_host_inst.stop();
  endtask

  // one pixel into an empty pipe; lat counts edges from take to output valid
  task automatic pixExp(input logic [7:0] r, g, b, er, eg, eb);
    int lat;
    @(posedge pixClk);
    pixInValid <= 1'h1;
    pixIn <= {3'h5, r, g, b};
    lat = 0;
    do begin
      @(negedge pixClk);
      lat++;
    end while (pixInReady !== 1'h1 && lat < 20);
    giveUp(lat >= 20);
    @(posedge pixClk);
    pixInValid <= 1'h0;
    lat = 0;
    do begin
      @(negedge pixClk);
      lat++;
    end while (pixOutValid !== 1'h1 && lat < 20);
    giveUp(lat >= 20);
    check("pixel", {5'h0, pixOut}, {5'h0, 3'h5, er, eg, eb});
    check("latency", lat, 3);
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic tReg();
    logic [7:0] v;
    logic       a;
    rd(8'h2A, v);
    check("page reset", v, WBL_PAGE_RST);
    wr(8'h2A, 8'h03);
    rd(8'h2A, v);
    check("page reserved", v, 8'h00);
    rd(8'h05, v);
    check("unmapped", v, 8'h00);
    wbl_i2c_host_inst.start();
    wbl_i2c_host_inst.putByte({ADDR ^ 7'h01, 1'h0}, a);
    wbl_i2c_host_inst.stop();
    check("foreign ack", a, 1'h0);
    $display("test registers done");
  endtask

  task automatic tFifo();
    int n;
    int i;
    int k;
    pixExp(8'h12, 8'h34, 8'h56, 8'h12, 8'h34, 8'h56);
    @(posedge pixClk);
    pixOutReady <= 1'h0;
    pixInValid <= 1'h1;
    pixIn <= mk(0);
    n = 0;
    while (n < 40) begin
      @(negedge pixClk);
      if (pixInReady !== 1'h1) break;
      n++;
      @(posedge pixClk);
      pixIn <= mk(n);
    end
    @(posedge pixClk);
    pixInValid <= 1'h0;
    check("fill", n >= WBL_FIFO_DEPTH && n < 40, 1'h1);
    i = 0;
    for (k = 0; i < n && k < 200; k++) begin
      @(posedge pixClk);
      pixOutReady <= k[0];
      @(negedge pixClk);
      if (pixOutValid === 1'h1 && pixOutReady === 1'h1) begin
        check("drain", {5'h0, pixOut}, {5'h0, mk(i)});
        i++;
      end
    end
    giveUp(k >= 200);
    @(posedge pixClk);
    pixOutReady <= 1'h1;
    @(negedge pixClk);
    check("empty", pixOutValid, 1'h0);
    $display("test buffer done");
  endtask

  task automatic tLoad();
    logic       a;
    logic [7:0] v;
    for (int t = 0; t < 3; t++) begin
      wr(8'h2A, {2'(t + 1), 6'h30});
      wbl_i2c_host_inst.start();
      wbl_i2c_host_inst.putByte({ADDR, 1'h0}, a);
      wbl_i2c_host_inst.putByte(8'h00, a);
      for (int i = 0; i < 256; i++) begin
        wbl_i2c_host_inst.putByte(lv(t, 8'(i)), a);
      end
      wbl_i2c_host_inst.stop();
    end
    wr(8'h2A, 8'hB0);
    rd(8'h3C, v);
    check("green entry", v, lv(1, 8'h3C));
    wbl_i2c_host_inst.start();
    wbl_i2c_host_inst.putByte({ADDR, 1'h1}, a);
    wbl_i2c_host_inst.getByte(1'h1, v);
    check("burst first", v, lv(1, 8'h3D));
    wbl_i2c_host_inst.getByte(1'h0, v);
    check("burst next", v, lv(1, 8'h3E));
    wbl_i2c_host_inst.stop();
    rd(8'h2A, v);
    check("hidden page", v, lv(1, 8'h2A));
    wr(8'hFF, lv(1, 8'hFF));
    rd(8'h2A, v);
    check("page exit", v, 8'hA0);
    $display("test load done");
  endtask

  task automatic tLive();
    logic [7:0] v;
    wr(8'h2A, WBL_PAGE_ENABLE);
    rd(8'h2A, v);
    check("enable", v, 8'h20);
    pixExp(8'h10, 8'h80, 8'hFE, lv(0, 8'h10), lv(1, 8'h80), lv(2, 8'hFE));
    wr(8'h2A, 8'h70);
    wr(8'h10, 8'hAB);
    wr(8'hFF, lv(0, 8'hFF));
    pixExp(8'h10, 8'h80, 8'hFE, lv(0, 8'h10), lv(1, 8'h80), lv(2, 8'hFE));
    wr(8'h2A, 8'h78);
    wr(8'h10, 8'hAB);
    rd(8'h10, v);
    check("reload read", v, 8'h00);
    wr(8'hFF, lv(0, 8'hFF));
    pixExp(8'h10, 8'h80, 8'hFE, 8'hAB, lv(1, 8'h80), lv(2, 8'hFE));
    wr(8'h2A, 8'h24);
    pixExp(8'h00, 8'h80, 8'hFE, dz(lv(0, 8'h00)), dz(lv(1, 8'h80)), dz(lv(2, 8'hFE)));
    $display("test live done");
  endtask

  initial begin
    sys_rst = 1'h1;
    pixInValid = 1'h0;
    pixOutReady = 1'h1;
    pixIn = '0;
    mismatches = 0;
    nChecks = 0;
    repeat (3) @(posedge core_clk);
    check("reset oe", sdaOeN, 1'h1);
    check("reset valid", pixOutValid, 1'h0);
    check("reset ready", pixInReady, 1'h1);
    @(posedge core_clk);
    sys_rst <= 1'h0;
    repeat (8) @(posedge core_clk);
    tReg();
    tFifo();
    tLoad();
    tLive();
    end_of_test();
  end
endmodule // wbl_lut_unit_tb
